// ==== srtc_pkg.sv ====
// srtc_pkg: shared constants of the secure rtc and nvram core
package srtc_pkg;
	// ==========================================
	// location space
	localparam int        SPACE_LEN   = 160;
	localparam int        PTR_W       = 8;
	localparam logic [6:0] DEV_ADDR   = 7'h68;
	localparam logic [7:0] TIME_LAST  = 8'h07;
	localparam logic [7:0] CTL_FIRST  = 8'h08;
	localparam logic [7:0] FLAGS_LOC  = 8'h0f;
	localparam logic [7:0] RSV_FIRST  = 8'h10;
	localparam logic [7:0] RSV_LAST   = 8'h12;
	localparam logic [7:0] TAMP1_LOC  = 8'h14;
	localparam logic [7:0] SER_FIRST  = 8'h16;
	localparam logic [7:0] SER_LAST   = 8'h1d;
	localparam logic [7:0] RAM_FIRST  = 8'h20;
	localparam logic [7:0] LAST_LOC   = 8'h9f;
	localparam int        RAM_DEPTH   = 128;
	// ==========================================
	// field positions
	localparam int TB_EN   = 7; // tamper channel enable
	localparam int TB_FLAG = 6; // tamper event seen
	localparam int TB_CLR  = 5; // clear internal ram on event
	localparam int TB_CLRX = 4; // signal external clear on event
	localparam int TB_NC   = 0; // 1: normally closed switch
	localparam int FLAG_OF = 2; // oscillator fail
	// ==========================================
	// reset values
	localparam logic [7:0] CTL_RST   = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h04;
	localparam logic [7:0] ONE_BCD   = 8'h01;
	// ==========================================
	// timing
	localparam int MCLK_PERIOD_NS = 10;
	localparam int HS_STEP        = 100;   // hundredths per second
	localparam int XTAL_HZ        = 32768; // time base
	localparam int OSC_STOP_NS    = 122000;
	localparam int OSC_STOP_CYC   = OSC_STOP_NS / MCLK_PERIOD_NS;
	localparam int DEB_NS         = 1000000;
	localparam int DEB_CYC        = DEB_NS / MCLK_PERIOD_NS;
	localparam int POR_NS         = 1000000;
	localparam int POR_CYC        = POR_NS / MCLK_PERIOD_NS;
	// ==========================================
	// serial bus states
	typedef enum logic [2:0] {
		SRTC_IDLE = 3'b000,
		SRTC_DEV  = 3'b001,
		SRTC_ADEV = 3'b010,
		SRTC_WR   = 3'b011,
		SRTC_AWR  = 3'b100,
		SRTC_RD   = 3'b101,
		SRTC_ARD  = 3'b110
	} srtc_state_t;
endpackage

// ==== srtc_cal.sv ====
// srtc_cal: bcd clock and calendar counters fed by the time base tick
`timescale 1ns/10ps
`default_nettype none
module srtc_cal (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        tick_i,
	input  wire logic        wr_i,
	input  wire logic [2:0]  wr_addr_i,
	input  wire logic [7:0]  wr_data_i,
	output logic      [63:0] time_o
);
	logic [7:0]  tm_q [8];
	logic [15:0] acc_q;
	logic [15:0] acc_n;
	logic        hs_tick;
	logic [7:0]  hr_nx;

	// ==========================================
	// helpers
	function automatic logic [7:0] bcd_nx(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] mdays(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon[4:0])
			5'h02: return leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// ==========================================
	// fractional step from 32.768 khz to hundredths
	assign acc_n   = acc_q + 16'(srtc_pkg::HS_STEP);
	assign hs_tick = tick_i && (acc_n >= 16'(srtc_pkg::XTAL_HZ));
	assign hr_nx   = bcd_nx({2'b00, tm_q[3][5:0]}); // next hour, century bits masked off

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_q <= 16'h0000;
		end else if (hs_tick) begin
			acc_q <= acc_n - 16'(srtc_pkg::XTAL_HZ);
		end else if (tick_i) begin
			acc_q <= acc_n;
		end
	end

	// ==========================================
	// counter cascade, 24 hour bcd with century in hours[7:6]
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 8; i++) begin
				tm_q[i] <= (i >= 4 && i <= 6) ? srtc_pkg::ONE_BCD : 8'h00;
			end
		end else if (wr_i) begin
			tm_q[wr_addr_i] <= wr_data_i;
		end else if (hs_tick) begin
			tm_q[0] <= (tm_q[0] == 8'h99) ? 8'h00 : bcd_nx(tm_q[0]);
			if (tm_q[0] == 8'h99) begin
				tm_q[1] <= (tm_q[1] == 8'h59) ? 8'h00 : bcd_nx(tm_q[1]);
				if (tm_q[1] == 8'h59) begin
					tm_q[2] <= (tm_q[2] == 8'h59) ? 8'h00 : bcd_nx(tm_q[2]);
					if (tm_q[2] == 8'h59) begin
						tm_q[3][5:0] <= (tm_q[3][5:0] == 6'h23) ? 6'h00 : hr_nx[5:0];
						if (tm_q[3][5:0] == 6'h23) begin
							tm_q[4] <= (tm_q[4] == 8'h07) ? srtc_pkg::ONE_BCD : bcd_nx(tm_q[4]);
							if (tm_q[5] == mdays(tm_q[6], tm_q[7])) begin
								tm_q[5] <= srtc_pkg::ONE_BCD;
								tm_q[6] <= (tm_q[6] == 8'h12) ? srtc_pkg::ONE_BCD : bcd_nx(tm_q[6]);
								if (tm_q[6] == 8'h12) begin
									tm_q[7] <= (tm_q[7] == 8'h99) ? 8'h00 : bcd_nx(tm_q[7]);
									if (tm_q[7] == 8'h99) begin
										tm_q[3][7:6] <= tm_q[3][7:6] + 2'b01;
									end
								end
							end else begin
								tm_q[5] <= bcd_nx(tm_q[5]);
							end
						end
					end
				end
			end
		end
	end

	assign time_o = {tm_q[7], tm_q[6], tm_q[5], tm_q[4], tm_q[3], tm_q[2], tm_q[1], tm_q[0]};
endmodule // srtc_cal
`default_nettype wire

// ==== srtc_core.sv ====
// srtc_core: serial slave, location space, tamper, reset and oscillator supervision
//
// How it works
// - 160 byte-wide locations hold time, control, serial number and user ram.
// - All timekeeping comes from the 32.768 khz time base.
// - Eight locations hold the clock and calendar in packed bcd.
// - Eleven further locations hold calibration, alarm, watchdog, tamper, square-wave control.
// - Eight read-only serial number bytes and 128 bytes of user ram.
// - The location pointer steps by one after every byte written or read.
// - Counts century down to hundredths, 24 hour bcd.
// - Month lengths 28, 29, 30, 31 handled, leap day inserted automatically.
// - Two debounced reset requests and power-on drive the reset output.
// - Two tamper channels with fully separate detection logic.
// - Each channel supervises a normally open or normally closed switch.
// - The first tamper event while no flag stands captures the current time for later reading.
// - An event may clear the internal ram, signal external clear, or both.
// - A readable flag shows the time base stopped or failed.
// - Time counters sit at 00h-07h, sub-second counter lowest.
// - User ram sits at 20h-9fh.
// - A supply fault aborts transfers, resets the pointer and ignores the bus.
`timescale 1ns/10ps
`default_nettype none
module srtc_core #(
	parameter int        OSC_STOP = srtc_pkg::OSC_STOP_CYC,
	parameter int        DEB      = srtc_pkg::DEB_CYC,
	parameter int        POR      = srtc_pkg::POR_CYC,
	parameter logic [63:0] SERIAL = 64'h0123456789abcdef // arbitrary value
) (
	input  wire logic       mclk_i,
	input  wire logic       rstn_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       osc_32k_i,
	input  wire logic [1:0] tamper_i,
	input  wire logic       rst_req1_n_i,
	input  wire logic       rst_req2_n_i,
	input  wire logic       supply_fault_i,
	output logic            rst_out_o,
	output logic            rst_out_oe_o,
	output logic            ext_clear_o
);
	if (OSC_STOP < 1 || DEB < 1 || POR < 1) begin : g_bad_count
		$error("srtc_core: counts must be at least one");
	end

	// ==========================================
	// pin synchronisers: stage a feeds stage b only
	localparam int NS = 8;
	logic [NS-1:0] sy_a_q;
	logic [NS-1:0] sy_b_q;
	logic          scl_p_q;
	logic          sda_p_q;
	logic          osc_p_q;
	logic          scl_s, sda_s, osc_s, fault_s, req1_s, req2_s;
	logic [1:0]    tamp_s;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sy_a_q  <= '1;
			sy_b_q  <= '1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			osc_p_q <= 1'b1; // matches the synchroniser reset, no false tick
		end else begin
			sy_a_q  <= {scl_i, sda_i, osc_32k_i, supply_fault_i, rst_req1_n_i, rst_req2_n_i, tamper_i};
			sy_b_q  <= sy_a_q;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			osc_p_q <= osc_s;
		end
	end
	assign {scl_s, sda_s, osc_s, fault_s, req1_s, req2_s, tamp_s} = sy_b_q;

	// ==========================================
	// time base edges and oscillator fail watch
	logic        tick;
	logic [31:0] osc_cnt_q;
	logic        of_q;
	logic        wr_en;
	logic [7:0]  ptr_q;
	logic [7:0]  shreg_q;
	assign tick = osc_s && !osc_p_q;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_cnt_q <= 32'h0;
			of_q      <= srtc_pkg::FLAGS_RST[srtc_pkg::FLAG_OF];
		end else begin
			osc_cnt_q <= tick ? 32'h0 : (osc_cnt_q == 32'(OSC_STOP) ? osc_cnt_q : osc_cnt_q + 32'h1);
			if (osc_cnt_q == 32'(OSC_STOP)) begin
				of_q <= 1'b1;
			end else if (wr_en && ptr_q == srtc_pkg::FLAGS_LOC && !shreg_q[srtc_pkg::FLAG_OF]) begin
				of_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// calendar
	logic [63:0] time_w;
	srtc_cal u_cal (
		.mclk_i    (mclk_i),
		.rstn_i    (rstn_i),
		.tick_i    (tick),
		.wr_i      (wr_en && ptr_q <= srtc_pkg::TIME_LAST),
		.wr_addr_i (ptr_q[2:0]),
		.wr_data_i (shreg_q),
		.time_o    (time_w)
	);

	// ==========================================
	// control bytes 08h-15h and user ram
	localparam int RAM_DEPTH_L = srtc_pkg::RAM_DEPTH;
	logic [7:0] ctl_q [24];
	logic [7:0] ram_q [RAM_DEPTH_L];
	logic       clr_busy_q;
	logic [6:0] clr_idx_q;
	logic [1:0] clr_go;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 24; i++) begin
				ctl_q[i] <= srtc_pkg::CTL_RST;
			end
		end else if (wr_en && ptr_q >= srtc_pkg::CTL_FIRST && ptr_q < srtc_pkg::SER_FIRST) begin
			ctl_q[5'(ptr_q - srtc_pkg::CTL_FIRST)] <= shreg_q;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (clr_busy_q) begin
			ram_q[clr_idx_q] <= 8'h00;
		end else if (wr_en && ptr_q >= srtc_pkg::RAM_FIRST && ptr_q <= srtc_pkg::LAST_LOC) begin
			ram_q[7'(ptr_q - srtc_pkg::RAM_FIRST)] <= shreg_q;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clr_busy_q <= 1'b0;
			clr_idx_q  <= 7'h00;
		end else if (|clr_go && !clr_busy_q) begin
			clr_busy_q <= 1'b1;
			clr_idx_q  <= 7'h00;
		end else if (clr_busy_q) begin
			clr_idx_q  <= clr_idx_q + 7'h01;
			clr_busy_q <= (clr_idx_q != 7'(RAM_DEPTH_L - 1));
		end
	end

	// ==========================================
	// tamper channels, one independent copy each
	logic [1:0]  tflag;
	logic [1:0]  tevent;
	logic [63:0] stamp_q;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tamp
			logic       flag_q;
			logic [7:0] cfg;
			logic [7:0] loc;
			assign loc       = srtc_pkg::TAMP1_LOC + 8'(g);
			assign cfg       = ctl_q[5'(loc - srtc_pkg::CTL_FIRST)];
			assign tevent[g] = cfg[srtc_pkg::TB_EN] && !flag_q
				&& (tamp_s[g] == !cfg[srtc_pkg::TB_NC]);
			assign clr_go[g] = tevent[g] && cfg[srtc_pkg::TB_CLR];
			assign tflag[g]  = flag_q;
			always_ff @(posedge mclk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					flag_q <= 1'b0;
				end else if (tevent[g]) begin
					flag_q <= 1'b1;
				end else if (wr_en && ptr_q == loc && !shreg_q[srtc_pkg::TB_FLAG]) begin
					flag_q <= 1'b0;
				end
			end
		end
	endgenerate

	// first event freezes a copy of the time, shown while any flag stands
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stamp_q     <= 64'h0;
			ext_clear_o <= 1'b0;
		end else begin
			if (|tevent && !(|tflag)) begin
				stamp_q <= time_w;
			end
			ext_clear_o <= (tflag[0] && ctl_q[5'(srtc_pkg::TAMP1_LOC - srtc_pkg::CTL_FIRST)][srtc_pkg::TB_CLRX])
				|| (tflag[1] && ctl_q[5'(srtc_pkg::TAMP1_LOC + 8'h01 - srtc_pkg::CTL_FIRST)][srtc_pkg::TB_CLRX]);
		end
	end

	// ==========================================
	// read data for the current pointer
	logic [7:0]  rd_data;
	logic [63:0] tview;
	logic [7:0]  pos;
	always_comb begin
		tview   = (|tflag) ? stamp_q : time_w;
		pos     = 8'h00;
		rd_data = 8'h00;
		if (ptr_q <= srtc_pkg::TIME_LAST) begin
			rd_data = tview[8*ptr_q[2:0] +: 8];
		end else if (ptr_q == srtc_pkg::FLAGS_LOC) begin
			rd_data = ctl_q[5'(ptr_q - srtc_pkg::CTL_FIRST)];
			rd_data[srtc_pkg::FLAG_OF] = of_q;
		end else if (ptr_q >= srtc_pkg::RSV_FIRST && ptr_q <= srtc_pkg::RSV_LAST) begin
			rd_data = 8'h00;
		end else if (ptr_q >= srtc_pkg::TAMP1_LOC && ptr_q < srtc_pkg::SER_FIRST) begin
			rd_data = ctl_q[5'(ptr_q - srtc_pkg::CTL_FIRST)];
			rd_data[srtc_pkg::TB_FLAG] = tflag[ptr_q[0]];
		end else if (ptr_q < srtc_pkg::SER_FIRST) begin
			rd_data = ctl_q[5'(ptr_q - srtc_pkg::CTL_FIRST)];
		end else if (ptr_q <= srtc_pkg::SER_LAST) begin
			pos     = ptr_q - srtc_pkg::SER_FIRST;
			rd_data = SERIAL[8*pos[2:0] +: 8];
		end else if (ptr_q >= srtc_pkg::RAM_FIRST && ptr_q <= srtc_pkg::LAST_LOC) begin
			rd_data = ram_q[7'(ptr_q - srtc_pkg::RAM_FIRST)];
		end
	end

	// ==========================================
	// serial slave
	srtc_pkg::srtc_state_t st_q;
	logic [3:0] cnt_q;
	logic [7:0] tx_q;
	logic       first_q;
	logic       nack_q;
	logic       rise, fall, start, stop;
	logic [7:0] ptr_nx;
	assign rise   = scl_s && !scl_p_q;
	assign fall   = !scl_s && scl_p_q;
	assign start  = scl_s && scl_p_q && !sda_s && sda_p_q;
	assign stop   = scl_s && scl_p_q && sda_s && !sda_p_q;
	assign ptr_nx = (ptr_q >= srtc_pkg::LAST_LOC) ? 8'h00 : ptr_q + 8'h01;
	assign wr_en  = fall && st_q == srtc_pkg::SRTC_WR && cnt_q == 4'h8 && !first_q && !fault_s;
	assign sda_o  = 1'b0;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q     <= srtc_pkg::SRTC_IDLE;
			cnt_q    <= 4'h0;
			shreg_q  <= 8'h00;
			tx_q     <= 8'h00;
			ptr_q    <= 8'h00;
			first_q  <= 1'b0;
			nack_q   <= 1'b1;
			sda_oe_o <= 1'b0;
		end else if (fault_s) begin
			st_q     <= srtc_pkg::SRTC_IDLE;
			ptr_q    <= 8'h00;
			sda_oe_o <= 1'b0;
		end else if (start || stop) begin
			st_q     <= start ? srtc_pkg::SRTC_DEV : srtc_pkg::SRTC_IDLE;
			cnt_q    <= 4'h0;
			sda_oe_o <= 1'b0;
		end else if (rise) begin
			if (st_q == srtc_pkg::SRTC_DEV || st_q == srtc_pkg::SRTC_WR || st_q == srtc_pkg::SRTC_RD) begin
				shreg_q <= {shreg_q[6:0], sda_s};
				cnt_q   <= cnt_q + 4'h1;
			end
			if (st_q == srtc_pkg::SRTC_ARD) begin
				nack_q <= sda_s;
			end
		end else if (fall) begin
			case (st_q)
				srtc_pkg::SRTC_DEV: begin
					if (cnt_q == 4'h8) begin
						st_q     <= (shreg_q[7:1] == srtc_pkg::DEV_ADDR) ? srtc_pkg::SRTC_ADEV : srtc_pkg::SRTC_IDLE;
						sda_oe_o <= (shreg_q[7:1] == srtc_pkg::DEV_ADDR);
					end
				end
				srtc_pkg::SRTC_ADEV: begin
					cnt_q <= 4'h0;
					if (shreg_q[0]) begin
						st_q     <= srtc_pkg::SRTC_RD;
						tx_q     <= rd_data;
						sda_oe_o <= !rd_data[7];
						ptr_q    <= ptr_nx;
					end else begin
						st_q     <= srtc_pkg::SRTC_WR;
						first_q  <= 1'b1;
						sda_oe_o <= 1'b0;
					end
				end
				srtc_pkg::SRTC_WR: begin
					if (cnt_q == 4'h8) begin
						st_q     <= srtc_pkg::SRTC_AWR;
						sda_oe_o <= 1'b1;
						first_q  <= 1'b0;
						ptr_q    <= first_q ? shreg_q : ptr_nx;
					end
				end
				srtc_pkg::SRTC_AWR: begin
					st_q     <= srtc_pkg::SRTC_WR;
					cnt_q    <= 4'h0;
					sda_oe_o <= 1'b0;
				end
				srtc_pkg::SRTC_RD: begin
					if (cnt_q == 4'h8) begin
						st_q     <= srtc_pkg::SRTC_ARD;
						sda_oe_o <= 1'b0;
					end else begin
						sda_oe_o <= !tx_q[3'(4'h7 - cnt_q)];
					end
				end
				srtc_pkg::SRTC_ARD: begin
					cnt_q <= 4'h0;
					if (nack_q) begin
						st_q <= srtc_pkg::SRTC_IDLE;
					end else begin
						st_q     <= srtc_pkg::SRTC_RD;
						tx_q     <= rd_data;
						sda_oe_o <= !rd_data[7];
						ptr_q    <= ptr_nx;
					end
				end
				default: st_q <= srtc_pkg::SRTC_IDLE;
			endcase
		end
	end

	// ==========================================
	// reset output: power-on stretch and debounced requests
	logic [31:0] por_q, deb1_q, deb2_q;
	logic        debounced_reset_request_1, debounced_reset_request_2;
	assign debounced_reset_request_1 = (deb1_q == 32'(DEB));
	assign debounced_reset_request_2 = (deb2_q == 32'(DEB));

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_q  <= 32'h0;
			deb1_q <= 32'h0;
			deb2_q <= 32'h0;
		end else begin
			deb1_q <= req1_s ? 32'h0 : (debounced_reset_request_1 ? deb1_q : deb1_q + 32'h1);
			deb2_q <= req2_s ? 32'h0 : (debounced_reset_request_2 ? deb2_q : deb2_q + 32'h1);
			if (debounced_reset_request_1 || debounced_reset_request_2) begin
				por_q <= 32'h0;
			end else if (por_q != 32'(POR)) begin
				por_q <= por_q + 32'h1;
			end
		end
	end
	assign rst_out_o    = 1'b0;
	assign rst_out_oe_o = (por_q != 32'(POR));
endmodule // srtc_core
`default_nettype wire

// ==== srtc_core_asserts.sv ====
// srtc_core_asserts: port-level checks of the secure rtc core
`timescale 1ns/10ps
`default_nettype none
module srtc_core_asserts #(
	parameter int DEB = 4,
	parameter int POR = 8
) (
	input wire logic       mclk_i,
	input wire logic       rstn_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       osc_32k_i,
	input wire logic [1:0] tamper_i,
	input wire logic       rst_req1_n_i,
	input wire logic       rst_req2_n_i,
	input wire logic       supply_fault_i,
	input wire logic       rst_out_o,
	input wire logic       rst_out_oe_o,
	input wire logic       ext_clear_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ==========================================
	// helper counters
	localparam int SAT = DEB + POR + 8;
	int por_cnt;
	int lo1_cnt;
	int lo2_cnt;
	int hi_cnt;
	// cycles since reset release and run lengths of the request pins
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			por_cnt <= 0;
			lo1_cnt <= 0;
			lo2_cnt <= 0;
			hi_cnt  <= 0;
		end else begin
			por_cnt <= (por_cnt < SAT) ? por_cnt + 1 : por_cnt;
			lo1_cnt <= rst_req1_n_i ? 0 : ((lo1_cnt < SAT) ? lo1_cnt + 1 : lo1_cnt);
			lo2_cnt <= rst_req2_n_i ? 0 : ((lo2_cnt < SAT) ? lo2_cnt + 1 : lo2_cnt);
			hi_cnt  <= !(rst_req1_n_i && rst_req2_n_i) ? 0 : ((hi_cnt < SAT) ? hi_cnt + 1 : hi_cnt);
		end
	end
	// ==========================================
	// assertions
	AST_POR_HOLD: assert property (por_cnt + 1 < POR |-> rst_out_oe_o)
		else $error("reset output released early after power-on");
	AST_REQ1_RESET: assert property (lo1_cnt >= DEB + 4 |-> rst_out_oe_o)
		else $error("first reset request did not assert reset output");
	AST_REQ2_RESET: assert property (lo2_cnt >= DEB + 4 |-> rst_out_oe_o)
		else $error("second reset request did not assert reset output");
	AST_STRETCH: assert property ($fell(rst_out_oe_o) |-> hi_cnt >= POR && por_cnt >= POR)
		else $error("reset output released before stretch ran out");
	AST_RST_OD: assert property (rst_out_oe_o |-> rst_out_o == 1'b0)
		else $error("reset output driven high");
	AST_FAULT_QUIET: assert property (supply_fault_i [*4] |-> !sda_oe_o)
		else $error("bus driven during supply fault");
	AST_ANSWER_ON_LOW: assert property ($rose(sda_oe_o) |-> !$past(scl_i, 2) || !$past(scl_i, 3) || !$past(scl_i, 4))
		else $error("data line pulled low outside clock low phase");
	AST_SDA_OD: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("data line driven high");
	AST_CLEAR_IDLE: assert property ($rose(rstn_i) |-> !ext_clear_o && !sda_oe_o)
		else $error("external clear or data line active after reset");
	// ==========================================
	// scenario coverage
	COV_EXT_CLEAR: cover property ($rose(ext_clear_o));
	COV_ACK: cover property ($rose(sda_oe_o));
	COV_REQ: cover property (lo1_cnt >= DEB + 4);
	COV_FAULT: cover property (supply_fault_i && !scl_i);
endmodule // srtc_core_asserts

bind srtc_core srtc_core_asserts #(.DEB(DEB), .POR(POR)) chk_u (
	.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .osc_32k_i(osc_32k_i), .tamper_i(tamper_i),
	.rst_req1_n_i(rst_req1_n_i), .rst_req2_n_i(rst_req2_n_i), .supply_fault_i(supply_fault_i),
	.rst_out_o(rst_out_o), .rst_out_oe_o(rst_out_oe_o), .ext_clear_o(ext_clear_o)
);
`default_nettype wire

// ==== srtc_host_model.sv ====
// srtc_host_model: two-wire bus master that reaches the core's locations
`timescale 1ns/10ps
`default_nettype none
module srtc_host_model (
	output logic       scl_o,
	output logic       sda_low_o,
	input  wire logic  sda_i,
	output logic [7:0] rd_byte_o,
	output logic       rd_valid_o
);
	// ==========================================
	// idle bus: clock high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		rd_byte_o = 8'h00;
		rd_valid_o = 1'b0;
	end
	// one 80 ns bit: 50 ns low, 30 ns high, sampled at the end of high
	task automatic clk_bit(input logic b, output logic s);
		#10 sda_low_o = ~b;
		#40 scl_o = 1'b1;
		#30 s = sda_i;
		scl_o = 1'b0;
	endtask
	// start or repeated start
	task automatic start();
		#10 sda_low_o = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_low_o = 1'b1;
		#40 scl_o = 1'b0;
	endtask
	// stop, leaves the bus idle
	task automatic stop();
		#10 sda_low_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_low_o = 1'b0;
		#40;
	endtask
	// byte out msb first, ack seen as a low line
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	// byte in, then ack or nack; each byte toggles the valid line
	task automatic get_byte(input logic nack);
		logic s;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(nack, s);
		rd_byte_o = d;
		rd_valid_o = ~rd_valid_o;
	endtask
	// pointer then data bytes; ok only if every byte was acknowledged
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$], output logic ok);
		logic a;
		start();
		put_byte(8'hd0, ok);
		put_byte(ptr, a);
		ok &= a;
		foreach (d[i]) begin
			put_byte(d[i], a);
			ok &= a;
		end
		stop();
	endtask
	// pointer, repeated start, then n bytes with nack on the last
	task automatic rd(input logic [7:0] ptr, input int n);
		logic a;
		start();
		put_byte(8'hd0, a);
		put_byte(ptr, a);
		start();
		put_byte(8'hd1, a);
		for (int i = 0; i < n; i++) get_byte(i == n - 1);
		stop();
	endtask
endmodule // srtc_host_model
`default_nettype wire

// ==== srtc_core_bench.sv ====
// srtc_core_bench: self-checking bench of the secure rtc core
`timescale 1ns/10ps
`default_nettype none
module srtc_core_bench;
	localparam int          DEB = 4;
	localparam int          POR = 8;
	localparam int          OSC = 50;
	localparam logic [63:0] SER = 64'h1122334455667788; // arbitrary value
	logic       mclk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic       osc_32k_i = 1'b0;
	logic       osc_run = 1'b1;
	logic [1:0] tamper_i = 2'b10;
	logic       rst_req1_n_i = 1'b1;
	logic       rst_req2_n_i = 1'b1;
	logic       supply_fault_i = 1'b0;
	wire        scl, sda_low, sda_line, sda_oe, rst_oe, ext_clr, rd_valid;
	wire [7:0]  rd_byte;
	logic [7:0] exp_q[$];
	int         err_count = 0;
	int         n_compared = 0;
	// ==========================================
	// clocks, pull-up on the data line
	always #5 mclk_i = ~mclk_i;
	always #100 if (osc_run) osc_32k_i = ~osc_32k_i;
	assign sda_line = !(sda_low || sda_oe);
	srtc_core #(.OSC_STOP(OSC), .DEB(DEB), .POR(POR), .SERIAL(SER)) dut_u (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
		.osc_32k_i(osc_32k_i), .tamper_i(tamper_i), .rst_req1_n_i(rst_req1_n_i),
		.rst_req2_n_i(rst_req2_n_i), .supply_fault_i(supply_fault_i), .rst_out_o(),
		.rst_out_oe_o(rst_oe), .ext_clear_o(ext_clr));
	srtc_host_model host_u (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line), .rd_byte_o(rd_byte),
		.rd_valid_o(rd_valid));
	// ==========================================
	// compare tasks and helpers
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e[$]);
		foreach (e[i]) exp_q.push_back(e[i]);
		host_u.rd(ptr, e.size());
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		logic ok;
		host_u.wr(ptr, d, ok);
		cmp_bit(ok, 1'b1);
	endtask
	task automatic req_low(input logic [1:0] m, input int n);
		{rst_req2_n_i, rst_req1_n_i} = ~m;
		cyc(n);
		{rst_req2_n_i, rst_req1_n_i} = 2'b11;
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// each byte read back is checked against the oldest note
	always @(rd_valid) if (rstn_i) cmp_byte(rd_byte, exp_q.pop_front());
	// ==========================================
	// main sequence
	initial begin
		logic [7:0] r[$];
		logic [7:0] se[$];
		logic ok;
		void'($urandom(96348));
		cyc(2);
		rstn_i = 1'b1;
		cmp_bit(rst_oe, 1'b1);
		cyc(POR + 6);
		cmp_bit(rst_oe, 1'b0);
		rd_chk(srtc_pkg::FLAGS_LOC, '{srtc_pkg::FLAGS_RST});
		wr(srtc_pkg::FLAGS_LOC, '{8'h00});
		rd_chk(srtc_pkg::FLAGS_LOC, '{8'h00});
		osc_run = 1'b0;
		cyc(OSC + 20);
		rd_chk(srtc_pkg::FLAGS_LOC, '{8'h04});
		osc_run = 1'b1;
		repeat (4) r.push_back(8'($urandom));
		wr(srtc_pkg::RAM_FIRST, r);
		rd_chk(srtc_pkg::RAM_FIRST, r);
		wr(srtc_pkg::LAST_LOC, '{r[0], 8'h00, 8'h42});
		rd_chk(srtc_pkg::LAST_LOC, '{r[0]});
		rd_chk(8'h01, '{8'h42});
		wr(srtc_pkg::SER_FIRST, '{8'hff});
		for (int i = 0; i < 8; i++) se.push_back(SER[8*i +: 8]);
		rd_chk(srtc_pkg::SER_FIRST, se);
		// channel 1 normally open with both clears, channel 2 normally closed
		wr(srtc_pkg::TAMP1_LOC, '{8'hb0, 8'h81});
		cyc(4);
		tamper_i[0] = 1'b1;
		cyc(200);
		cmp_bit(ext_clr, 1'b1);
		rd_chk(srtc_pkg::TAMP1_LOC, '{8'hf0, 8'h81});
		rd_chk(srtc_pkg::RAM_FIRST, '{8'h00, 8'h00});
		wr(8'h01, '{8'h17});
		rd_chk(8'h01, '{8'h42});
		tamper_i[0] = 1'b0;
		wr(srtc_pkg::TAMP1_LOC, '{8'h00});
		cyc(4);
		cmp_bit(ext_clr, 1'b0);
		tamper_i[1] = 1'b0;
		cyc(10);
		rd_chk(8'h15, '{8'hc1});
		rd_chk(8'h01, '{8'h17});
		cmp_bit(ext_clr, 1'b0);
		// short glitch is filtered, a full request from either pin resets
		req_low(2'b01, $urandom_range(DEB - 1, 1));
		cyc(3);
		cmp_bit(rst_oe, 1'b0);
		for (int m = 1; m <= 2; m++) begin
			req_low(2'(m), DEB + 5);
			cmp_bit(rst_oe, 1'b1);
			cyc(POR + 8);
			cmp_bit(rst_oe, 1'b0);
		end
		supply_fault_i = 1'b1;
		cyc(5);
		host_u.wr(srtc_pkg::RAM_FIRST, '{8'h5a}, ok);
		cmp_bit(ok, 1'b0);
		supply_fault_i = 1'b0;
		cyc(5);
		rd_chk(srtc_pkg::RAM_FIRST, '{8'h00});
		complete_run();
	end
	// watchdog, well beyond the expected run length
	initial begin
		#500000;
		err_count++;
		complete_run();
	end
endmodule // srtc_core_bench
`default_nettype wire
